//--- hw/pq_pkg.sv
package pq_pkg;
	// register offsets
	localparam logic [7:0] ADDR_MODE_CONTROL_TWO     = 8'h0c;
	localparam logic [7:0] ADDR_CROSSING_TIMEOUT_VALUE    = 8'h11;
	localparam logic [7:0] ADDR_LINE_MEAS = 8'h20;
	localparam logic [7:0] ADDR_DIP_THR   = 8'h21;
	localparam logic [7:0] ADDR_DIP_CYC   = 8'h22;
	localparam logic [7:0] ADDR_VPK_THR   = 8'h23;
	localparam logic [7:0] ADDR_IPK_THR   = 8'h24;
	localparam logic [7:0] ADDR_VMAX      = 8'h25;
	localparam logic [7:0] ADDR_IMAX      = 8'h26;
	localparam logic [7:0] ADDR_VMAX_COR  = 8'h27;
	localparam logic [7:0] ADDR_IMAX_COR  = 8'h28;
	localparam logic [7:0] ADDR_ST3       = 8'h30;
	localparam logic [7:0] ADDR_EN3       = 8'h31;
	localparam logic [7:0] ADDR_SM_FLAGS  = 8'h32;
	localparam logic [7:0] ADDR_SM_EN     = 8'h33;
	// field positions
	localparam int BIT_FREQ_SEL = 0;
	localparam int BIT_ZX       = 0;
	localparam int BIT_CROSSING_TIMEOUT_ENABLE     = 1;
	localparam int BIT_PKV      = 2;
	localparam int BIT_PKI      = 3;
	localparam int BIT_DIP      = 0;
	// values after reset
	localparam logic [11:0] CROSSING_TIMEOUT_VALUE_RST  = 12'hfff;
	localparam logic [15:0] DIP_THR_RST = 16'h0000;
	localparam logic [7:0]  DIP_CYC_RST = 8'h02;
	localparam logic [15:0] PK_THR_RST  = 16'hffff;
	// clock rate, cycle counts and divider constants
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam logic [7:0]  CROSSING_TIMEOUT_ENABLE_DIV    = 8'd160;
	localparam logic [3:0]  PER_DIV     = 4'd10;
	localparam logic [27:0] FREQ_NUM    = 28'(64'd16 * CLK_HZ / PER_DIV);
	localparam logic [4:0]  DIV_STEPS   = 5'd28;
	typedef enum logic [0:0] {
		DIV_IDLE = 1'b0,
		DIV_RUN  = 1'b1
	} div_state_t;
endpackage

//--- hw/line_power_quality_monitor.sv
// Implementation choice: the plain strobed port.
module line_power_quality_monitor (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// filtered voltage stream
	input  wire logic        lpf_valid,
	input  wire logic [15:0] lpf_sample,
	// raw channel waveform samples
	input  wire logic        wave_valid,
	input  wire logic [23:0] v_wave,
	input  wire logic [23:0] i_wave,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// events and interrupts
	output logic             zero_cross_event,
	output logic             metering_irq,
	output logic             supply_monitor_irq
);
	typedef struct packed {
		logic [15:0]        rdata;
		logic               mode_freq;
		logic [11:0]        crossing_timeout_enable_val;
		logic [11:0]        crossing_timeout_enable_cnt;
		logic [7:0]         crossing_timeout_enable_pre;
		logic [15:0]        v_prev;
		logic               zx;
		logic [3:0]         per_pre;
		logic [15:0]        per_cnt;
		logic [15:0]        meas;
		logic [15:0]        dip_thr;
		logic [7:0]         dip_cyc;
		logic [7:0]         dip_run;
		logic               cyc_below;
		logic [15:0]        vpk_thr;
		logic [15:0]        ipk_thr;
		logic [15:0]        vmax;
		logic [15:0]        imax;
		logic [3:0]         st3;
		logic [3:0]         en3;
		logic               sm_flag;
		logic               sm_en;
		pq_pkg::div_state_t dstate;
		logic [4:0]         dstep;
		logic [27:0]        dquo;
		logic [16:0]        drem;
		logic [15:0]        dden;
	} state_t;

	state_t      r_ff;
	state_t      nxt_r;
	logic        zx_now;
	logic        pos_now;
	logic        crossing_timeout_enable_tick;
	logic        below_now;
	logic        dip_ok;
	logic [7:0]  run_inc;
	logic [15:0] abs_lpf;
	logic [15:0] abs_v;
	logic [15:0] abs_i;
	logic        wr_st3;
	logic        rd_vcor;
	logic        rd_icor;

	function automatic logic [15:0] mag(input logic [15:0] x);
		mag = x[15] ? 16'(-x) : x;
	endfunction

	// crossing detector on the low-pass output
	// sign change
	assign zx_now    = lpf_valid && (lpf_sample[15] != r_ff.v_prev[15]);
	assign pos_now   = zx_now && !lpf_sample[15];
	assign crossing_timeout_enable_tick = r_ff.crossing_timeout_enable_pre == 8'(pq_pkg::CROSSING_TIMEOUT_ENABLE_DIV - 8'd1);
	assign abs_lpf   = mag(lpf_sample);
	assign abs_v     = mag(v_wave[23:8]);
	assign abs_i     = mag(i_wave[23:8]);
	assign below_now = r_ff.dip_thr > abs_lpf;
	assign dip_ok    = r_ff.cyc_below && (below_now || !lpf_valid);
	assign run_inc   = r_ff.dip_run + 8'd1;
	assign wr_st3    = reg_wr && reg_addr == pq_pkg::ADDR_ST3;
	assign rd_vcor   = reg_rd && reg_addr == pq_pkg::ADDR_VMAX_COR;
	assign rd_icor   = reg_rd && reg_addr == pq_pkg::ADDR_IMAX_COR;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.zx = zx_now;
		if (lpf_valid) begin
			nxt_r.v_prev = lpf_sample;
		end

		nxt_r.crossing_timeout_enable_pre = crossing_timeout_enable_tick ? 8'h00 : 8'(r_ff.crossing_timeout_enable_pre + 8'd1);
		if (zx_now) begin
			nxt_r.crossing_timeout_enable_cnt = r_ff.crossing_timeout_enable_val;
			nxt_r.crossing_timeout_enable_pre = 8'h00;
		end else if (crossing_timeout_enable_tick && r_ff.crossing_timeout_enable_cnt != 12'h000) begin
			nxt_r.crossing_timeout_enable_cnt = 12'(r_ff.crossing_timeout_enable_cnt - 12'd1);
		end

		nxt_r.per_pre = (r_ff.per_pre == 4'(pq_pkg::PER_DIV - 4'd1)) ? 4'h0
			: 4'(r_ff.per_pre + 4'd1);
		if (r_ff.per_pre == 4'(pq_pkg::PER_DIV - 4'd1) && r_ff.per_cnt != 16'hffff) begin
			nxt_r.per_cnt = 16'(r_ff.per_cnt + 16'd1);
		end

		// sixteenths of hertz by long division
		case (r_ff.dstate)
			pq_pkg::DIV_IDLE: begin
				nxt_r.dstep = 5'd0;
			end
			pq_pkg::DIV_RUN: begin
				if ({r_ff.drem[15:0], r_ff.dquo[27]} >= {1'b0, r_ff.dden}) begin
					nxt_r.drem = 17'({r_ff.drem[15:0], r_ff.dquo[27]} - {1'b0, r_ff.dden});
					nxt_r.dquo = {r_ff.dquo[26:0], 1'b1};
				end else begin
					nxt_r.drem = {r_ff.drem[15:0], r_ff.dquo[27]};
					nxt_r.dquo = {r_ff.dquo[26:0], 1'b0};
				end
				nxt_r.dstep = 5'(r_ff.dstep + 5'd1);
				if (r_ff.dstep == 5'(pq_pkg::DIV_STEPS - 5'd1)) begin
					nxt_r.dstate = pq_pkg::DIV_IDLE;
					nxt_r.meas = (|nxt_r.dquo[27:16]) ? 16'hffff : nxt_r.dquo[15:0];
				end
			end
			default: begin
				nxt_r.dstate = pq_pkg::DIV_IDLE;
			end
		endcase

		// below-threshold tracking over the running cycle
		if (lpf_valid && !below_now) begin
			nxt_r.cyc_below = 1'b0;
		end

		if (pos_now) begin
			nxt_r.per_cnt = 16'h0000;
			nxt_r.per_pre = 4'h0;
			if (!r_ff.mode_freq) begin
				nxt_r.meas = r_ff.per_cnt;
			end else if (r_ff.per_cnt != 16'h0000) begin
				nxt_r.dstate = pq_pkg::DIV_RUN;
				nxt_r.dstep  = 5'd0;
				nxt_r.dquo   = pq_pkg::FREQ_NUM;
				nxt_r.drem   = 17'h00000;
				nxt_r.dden   = r_ff.per_cnt;
			end
			if (dip_ok) begin
				nxt_r.dip_run = (r_ff.dip_run == 8'hff) ? 8'hff : run_inc;
			end else begin
				nxt_r.dip_run = 8'h00;
			end
			nxt_r.cyc_below = 1'b1;
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				pq_pkg::ADDR_MODE_CONTROL_TWO: begin
					nxt_r.mode_freq = reg_wdata[pq_pkg::BIT_FREQ_SEL];
				end
				pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE: begin
					nxt_r.crossing_timeout_enable_val = reg_wdata[11:0];
				end
				pq_pkg::ADDR_DIP_THR: begin
					nxt_r.dip_thr = reg_wdata;
				end
				pq_pkg::ADDR_DIP_CYC: begin
					nxt_r.dip_cyc = reg_wdata[7:0];
				end
				pq_pkg::ADDR_VPK_THR: begin
					nxt_r.vpk_thr = reg_wdata;
				end
				pq_pkg::ADDR_IPK_THR: begin
					nxt_r.ipk_thr = reg_wdata;
				end
				pq_pkg::ADDR_EN3: begin
					nxt_r.en3 = reg_wdata[3:0];
				end
				pq_pkg::ADDR_SM_FLAGS: begin
					if (reg_wdata[pq_pkg::BIT_DIP]) begin
						nxt_r.sm_flag = 1'b0;
					end
				end
				pq_pkg::ADDR_SM_EN: begin
					nxt_r.sm_en = reg_wdata[pq_pkg::BIT_DIP];
				end
				default: begin
				end
			endcase
		end
		if (wr_st3) begin
			nxt_r.st3 = r_ff.st3 & ~reg_wdata[3:0];
		end

		if (rd_vcor) begin
			nxt_r.vmax = 16'h0000;
		end
		if (rd_icor) begin
			nxt_r.imax = 16'h0000;
		end

		// hardware sets win over software clears
		// crossing flag
		if (zx_now) begin
			nxt_r.st3[pq_pkg::BIT_ZX] = 1'b1;
		end
		if (!zx_now && crossing_timeout_enable_tick && r_ff.crossing_timeout_enable_cnt == 12'd1) begin
			nxt_r.st3[pq_pkg::BIT_CROSSING_TIMEOUT_ENABLE] = 1'b1;
		end
		if (pos_now && dip_ok && run_inc == 8'(r_ff.dip_cyc - 8'd1)) begin
			nxt_r.sm_flag = 1'b1;
		end
		if (wave_valid) begin
			if (abs_v > r_ff.vpk_thr) begin
				nxt_r.st3[pq_pkg::BIT_PKV] = 1'b1;
			end
			if (abs_i > r_ff.ipk_thr) begin
				nxt_r.st3[pq_pkg::BIT_PKI] = 1'b1;
			end
			if (abs_v > r_ff.vmax) begin
				nxt_r.vmax = abs_v;
			end
			if (abs_i > r_ff.imax) begin
				nxt_r.imax = abs_i;
			end
		end

		// read data stand for one cycle only
		nxt_r.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				pq_pkg::ADDR_MODE_CONTROL_TWO:     nxt_r.rdata = {15'h0000, r_ff.mode_freq};
				pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE:    nxt_r.rdata = {4'h0, r_ff.crossing_timeout_enable_val};
				pq_pkg::ADDR_LINE_MEAS: nxt_r.rdata = r_ff.meas;
				pq_pkg::ADDR_DIP_THR:   nxt_r.rdata = r_ff.dip_thr;
				pq_pkg::ADDR_DIP_CYC:   nxt_r.rdata = {8'h00, r_ff.dip_cyc};
				pq_pkg::ADDR_VPK_THR:   nxt_r.rdata = r_ff.vpk_thr;
				pq_pkg::ADDR_IPK_THR:   nxt_r.rdata = r_ff.ipk_thr;
				pq_pkg::ADDR_VMAX:      nxt_r.rdata = r_ff.vmax;
				pq_pkg::ADDR_IMAX:      nxt_r.rdata = r_ff.imax;
				pq_pkg::ADDR_VMAX_COR:  nxt_r.rdata = r_ff.vmax;
				pq_pkg::ADDR_IMAX_COR:  nxt_r.rdata = r_ff.imax;
				pq_pkg::ADDR_ST3:       nxt_r.rdata = {12'h000, r_ff.st3};
				pq_pkg::ADDR_EN3:       nxt_r.rdata = {12'h000, r_ff.en3};
				pq_pkg::ADDR_SM_FLAGS:  nxt_r.rdata = {15'h0000, r_ff.sm_flag};
				pq_pkg::ADDR_SM_EN:     nxt_r.rdata = {15'h0000, r_ff.sm_en};
				default:                nxt_r.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r_ff          <= '0;
			r_ff.crossing_timeout_enable_val <= pq_pkg::CROSSING_TIMEOUT_VALUE_RST;
			r_ff.crossing_timeout_enable_cnt <= pq_pkg::CROSSING_TIMEOUT_VALUE_RST;
			r_ff.dip_thr  <= pq_pkg::DIP_THR_RST;
			r_ff.dip_cyc  <= pq_pkg::DIP_CYC_RST;
			r_ff.vpk_thr  <= pq_pkg::PK_THR_RST;
			r_ff.ipk_thr  <= pq_pkg::PK_THR_RST;
			r_ff.dstate   <= pq_pkg::DIV_IDLE;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign reg_rdata          = r_ff.rdata;
	assign zero_cross_event   = r_ff.zx;
	assign metering_irq       = |(r_ff.st3 & r_ff.en3);
	assign supply_monitor_irq = r_ff.sm_flag && r_ff.sm_en;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence crossing_timeout_enable_tick_s;
		crossing_timeout_enable_tick && !zx_now && r_ff.crossing_timeout_enable_cnt != 12'h000;
	endsequence

	sequence cor_read_s;
		rd_vcor && !(wave_valid && abs_v > 16'h0000);
	endsequence

	AST_ZX_SIGN: assert property (zx_now |=> r_ff.zx && r_ff.st3[pq_pkg::BIT_ZX])
		else $error("crossing not flagged");
	AST_CROSSING_TIMEOUT_ENABLE_RELOAD: assert property (zx_now |=> r_ff.crossing_timeout_enable_cnt == $past(r_ff.crossing_timeout_enable_val))
		else $error("timeout not reloaded");
	AST_CROSSING_TIMEOUT_ENABLE_DEC: assert property (crossing_timeout_enable_tick_s |=> r_ff.crossing_timeout_enable_cnt == $past(r_ff.crossing_timeout_enable_cnt) - 1)
		else $error("timeout not decremented");
	AST_CROSSING_TIMEOUT_ENABLE_FLAG: assert property ((crossing_timeout_enable_tick_s ##0 r_ff.crossing_timeout_enable_cnt == 12'd1)
		|=> r_ff.crossing_timeout_enable_cnt == 12'h000 && r_ff.st3[pq_pkg::BIT_CROSSING_TIMEOUT_ENABLE])
		else $error("timeout flag missing");
	AST_CROSSING_TIMEOUT_ENABLE_PACE: assert property ((!zx_now && r_ff.crossing_timeout_enable_pre == 8'h00) ##1 !zx_now
		|-> r_ff.crossing_timeout_enable_pre == 8'h01)
		else $error("prescaler misstep");
	AST_PER_LATCH: assert property ((pos_now && !r_ff.mode_freq)
		|=> r_ff.meas == $past(r_ff.per_cnt) && r_ff.per_cnt == 16'h0000)
		else $error("period not latched");
	AST_DIV_END: assert property ((r_ff.dstate == pq_pkg::DIV_RUN && r_ff.dstep == 5'd27
		&& !pos_now) |=> r_ff.dstate == pq_pkg::DIV_IDLE)
		else $error("divider overran");
	AST_PKV: assert property ((wave_valid && abs_v > r_ff.vpk_thr)
		|=> r_ff.st3[pq_pkg::BIT_PKV] && metering_irq == $past(r_ff.en3[pq_pkg::BIT_PKV])
		|| r_ff.en3 != $past(r_ff.en3) || (r_ff.st3 & r_ff.en3) != 4'h0)
		else $error("voltage peak not flagged");
	AST_VMAX: assert property ((wave_valid && abs_v > r_ff.vmax)
		|=> r_ff.vmax == $past(abs_v))
		else $error("voltage record not updated");
	AST_COR: assert property (cor_read_s |=> r_ff.vmax == 16'h0000
		&& reg_rdata == $past(r_ff.vmax))
		else $error("clear-on-read failed");
	AST_DIP: assert property ((pos_now && dip_ok && run_inc == 8'(r_ff.dip_cyc - 8'd1))
		|=> r_ff.sm_flag)
		else $error("dip flag missing");
	AST_DIP_RESTART: assert property ((pos_now && !dip_ok) |=> r_ff.dip_run == 8'h00)
		else $error("dip count not restarted");

endmodule // line_power_quality_monitor

//--- tb/sample_source.sv
module sample_source (
	// clock
	input  wire logic        ref_clk,
	// streams toward the monitor
	output logic             lpf_valid,
	output logic      [15:0] lpf_sample,
	output logic             wave_valid,
	output logic      [23:0] v_wave,
	output logic      [23:0] i_wave
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		lpf_valid = 1'b0;
		lpf_sample = 16'h0000;
		wave_valid = 1'b0;
		v_wave = 24'h000000;
		i_wave = 24'h000000;
	end
	// idle data lines show the inverse of the last sample
	task automatic send_lpf(input logic [15:0] s);
		@(posedge ref_clk);
		lpf_valid <= 1'b1;
		lpf_sample <= s;
		@(posedge ref_clk);
		lpf_valid <= 1'b0;
		lpf_sample <= ~s;
	endtask
	task automatic send_wave(input logic [23:0] v, input logic [23:0] i);
		@(posedge ref_clk);
		wave_valid <= 1'b1;
		v_wave <= v;
		i_wave <= i;
		@(posedge ref_clk);
		wave_valid <= 1'b0;
		v_wave <= ~v;
		i_wave <= ~i;
	endtask
endmodule // sample_source

//--- tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FGAP = 14998;
	logic        ref_clk, rst_n, reg_wr, reg_rd, lpf_valid, wave_valid;
	logic        zero_cross_event, metering_irq, supply_monitor_irq;
	logic [15:0] lpf_sample, reg_wdata, reg_rdata, d;
	logic [23:0] v_wave, i_wave;
	logic [7:0]  reg_addr;
	int          n_fail = 0;
	int          n_checks = 0;

	line_power_quality_monitor i_line_power_quality_monitor (
		.ref_clk(ref_clk), .rst_n(rst_n), .lpf_valid(lpf_valid), .lpf_sample(lpf_sample),
		.wave_valid(wave_valid), .v_wave(v_wave), .i_wave(i_wave), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.zero_cross_event(zero_cross_event), .metering_irq(metering_irq),
		.supply_monitor_irq(supply_monitor_irq)
	);
	sample_source i_sample_source (
		.ref_clk(ref_clk), .lpf_valid(lpf_valid), .lpf_sample(lpf_sample),
		.wave_valid(wave_valid), .v_wave(v_wave), .i_wave(i_wave)
	);

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string w);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h want %h", $time, w, seen, exp);
		end
	endtask
	task automatic bit1(input logic b, input logic e, input string w);
		check({15'h0, b}, {15'h0, e}, w);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic crd(input logic [7:0] a, input logic [15:0] e, input string w);
		logic [15:0] v;
		rd(a, v);
		check(v, e, w);
	endtask
	task automatic near(input logic [7:0] a, input int e, input int t, input string w);
		logic [15:0] v;
		rd(a, v);
		bit1(v >= 16'(e - t) && v <= 16'(e + t), 1'b1, w);
	endtask
	// one rising crossing per call, 2*(g+2) cycles apart
	task automatic rise(input logic [15:0] m, input int g);
		i_sample_source.send_lpf(-m);
		repeat (g) @(posedge ref_clk);
		i_sample_source.send_lpf(m);
		repeat (g) @(posedge ref_clk);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#900000;
		n_fail++;
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		crd(pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE, 16'h0fff, "timeout reset");
		crd(8'h3f, 16'h0000, "unmapped");
		wr(pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE, 16'h0123);
		crd(pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE, 16'h0123, "timeout rw");
		wr(pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE, 16'h0fff);
		wr(pq_pkg::ADDR_VMAX, 16'h1234);
		crd(pq_pkg::ADDR_VMAX, 16'h0000, "record ro");
		$display("registers done");
		wr(pq_pkg::ADDR_EN3, 16'h0001);
		i_sample_source.send_lpf(16'hfff0);
		i_sample_source.send_lpf(16'h0010);
		#1 bit1(zero_cross_event, 1'b1, "rise pulse");
		@(posedge ref_clk);
		#1 bit1(zero_cross_event, 1'b0, "pulse length");
		i_sample_source.send_lpf(16'hfff0);
		#1 bit1(zero_cross_event, 1'b1, "fall pulse");
		crd(pq_pkg::ADDR_ST3, 16'h0001, "crossing flag");
		bit1(metering_irq, 1'b1, "irq on");
		wr(pq_pkg::ADDR_EN3, 16'h0000);
		#1 bit1(metering_irq, 1'b0, "irq masked");
		wr(pq_pkg::ADDR_EN3, 16'h0001);
		wr(pq_pkg::ADDR_ST3, 16'h0001);
		#1 bit1(metering_irq, 1'b0, "irq cleared");
		crd(pq_pkg::ADDR_ST3, 16'h0000, "flag cleared");
		$display("crossing done");
		repeat (3) rise(16'h0010, 498);
		near(pq_pkg::ADDR_LINE_MEAS, 100, 1, "period");
		wr(pq_pkg::ADDR_MODE_CONTROL_TWO, 16'h0001);
		repeat (2) rise(16'h0010, FGAP);
		near(pq_pkg::ADDR_LINE_MEAS, 16 * pq_pkg::CLK_HZ / 10 / ((2 * (FGAP + 2)) / 10), 20,
			"frequency");
		wr(pq_pkg::ADDR_MODE_CONTROL_TWO, 16'h0000);
		$display("line measure done");
		wr(pq_pkg::ADDR_DIP_THR, 16'h0100);
		wr(pq_pkg::ADDR_DIP_CYC, 16'h0004);
		wr(pq_pkg::ADDR_SM_EN, 16'h0001);
		rise(16'h0200, 4);
		repeat (2) rise(16'h0010, 4);
		rise(16'h0200, 4);
		repeat (2) rise(16'h0010, 4);
		crd(pq_pkg::ADDR_SM_FLAGS, 16'h0000, "dip restart");
		repeat (2) rise(16'h0010, 4);
		crd(pq_pkg::ADDR_SM_FLAGS, 16'h0001, "dip flag");
		bit1(supply_monitor_irq, 1'b1, "supply irq");
		wr(pq_pkg::ADDR_SM_FLAGS, 16'h0001);
		#1 bit1(supply_monitor_irq, 1'b0, "supply clear");
		$display("dip done");
		wr(pq_pkg::ADDR_VPK_THR, 16'h1000);
		wr(pq_pkg::ADDR_IPK_THR, 16'h2000);
		wr(pq_pkg::ADDR_ST3, 16'h000f);
		i_sample_source.send_wave(24'h180000, 24'he80000);
		crd(pq_pkg::ADDR_ST3, 16'h0004, "voltage peak");
		i_sample_source.send_wave(24'h080000, 24'hd00000);
		crd(pq_pkg::ADDR_ST3, 16'h000c, "current peak");
		crd(pq_pkg::ADDR_VMAX, 16'h1800, "v record");
		crd(pq_pkg::ADDR_VMAX_COR, 16'h1800, "v alias");
		crd(pq_pkg::ADDR_VMAX, 16'h0000, "v cleared");
		crd(pq_pkg::ADDR_IMAX_COR, 16'h3000, "i alias");
		crd(pq_pkg::ADDR_IMAX, 16'h0000, "i cleared");
		$display("peak done");
		wr(pq_pkg::ADDR_CROSSING_TIMEOUT_VALUE, 16'h0002);
		wr(pq_pkg::ADDR_EN3, 16'h0002);
		i_sample_source.send_lpf(16'hfff0);
		wr(pq_pkg::ADDR_ST3, 16'h000f);
		repeat (148) @(posedge ref_clk);
		rd(pq_pkg::ADDR_ST3, d);
		bit1(d[1], 1'b0, "timeout early");
		repeat (175) @(posedge ref_clk);
		rd(pq_pkg::ADDR_ST3, d);
		bit1(d[1], 1'b1, "timeout flag");
		bit1(metering_irq, 1'b1, "timeout irq");
		$display("timeout done");
		give_verdict();
	end
endmodule // testbench
